// >>> hw/sct_pkg.sv
/*
   Constants, register map and state layout of the capture/compare timer.
   Assumes an AXI4-Lite master with 8-bit addressing of one word per register.
*/
`default_nettype none
package sct_pkg;
   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [7:0] A_CTL1    = 8'h00;
   localparam logic [7:0] A_CTL2    = 8'h04;
   localparam logic [7:0] A_FLAGS   = 8'h08;
   localparam logic [7:0] A_CAP1_HI = 8'h0c;
   localparam logic [7:0] A_CAP1_LO = 8'h10;
   localparam logic [7:0] A_CAP2_HI = 8'h14;
   localparam logic [7:0] A_CAP2_LO = 8'h18;
   localparam logic [7:0] A_CMP1_HI = 8'h1c;
   localparam logic [7:0] A_CMP1_LO = 8'h20;
   localparam logic [7:0] A_CMP2_HI = 8'h24;
   localparam logic [7:0] A_CMP2_LO = 8'h28;
   localparam logic [7:0] A_CNT_HI  = 8'h2c;
   localparam logic [7:0] A_CNT_LO  = 8'h30;
   localparam logic [7:0] A_ALT_HI  = 8'h34;
   localparam logic [7:0] A_ALT_LO  = 8'h38;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int B1_CAP_IE    = 7;
   localparam int B1_CMP_IE    = 6;
   localparam int B1_OVF_IE    = 5;
   localparam int B1_FORCE2    = 4;
   localparam int B1_FORCE1    = 3;
   localparam int B1_LVL2      = 2;
   localparam int B1_EDGE1     = 1;
   localparam int B1_LVL1      = 0;
   localparam int B2_PIN1_EN   = 7;
   localparam int B2_PIN2_EN   = 6;
   localparam int B2_ONE_PULSE = 5;
   localparam int B2_PWM       = 4;
   localparam int B2_CLK_HI    = 3;
   localparam int B2_CLK_LO    = 2;
   localparam int B2_EDGE2     = 1;
   localparam int B2_EXT_EDGE  = 0;
   localparam int F_CAP1       = 4;
   localparam int F_CMP1       = 3;
   localparam int F_OVF        = 2;
   localparam int F_CAP2       = 1;
   localparam int F_CMP2       = 0;
   // ----------------------------------------
   // Reset values and codes
   // ----------------------------------------
   localparam logic [7:0]  CTL_RST   = 8'h00;
   localparam logic [4:0]  FLAGS_RST = 5'h00;
   localparam logic [2:0]  FLAGS_PAD = 3'h0;
   localparam logic [15:0] CNT_RST   = 16'hfffc;
   localparam logic [15:0] CNT_MAX   = 16'hffff;
   localparam logic [15:0] CAP_OPM   = 16'hfffd;
   localparam logic [15:0] CMP_RST   = 16'h8000;
   localparam logic [1:0]  CLK_DIV4  = 2'h0;
   localparam logic [1:0]  CLK_DIV2  = 2'h1;
   localparam logic [1:0]  CLK_DIV8  = 2'h2;
   localparam logic [1:0]  RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_ERR  = 2'h2;
   // ----------------------------------------
   // Whole state of the timer
   // ----------------------------------------
   typedef struct packed {
      logic [7:0]  ctl1;
      logic [7:0]  ctl2;
      logic [4:0]  flags;
      logic [4:0]  arm;
      logic [15:0] cnt;
      logic [15:0] cap1;
      logic [15:0] cap2;
      logic [15:0] cmp1;
      logic [15:0] cmp2;
      logic [1:0]  cmp_inh;
      logic [1:0]  halt_arm;
      logic        pin1;
      logic        pin2;
      logic [2:0]  pre;
      logic        ext_q;
      logic        cap1_q;
      logic        cap2_q;
      logic        halt_q;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [7:0]  wdata;
      logic        wstrb0;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [7:0]  rdata;
      logic [1:0]  rresp;
      logic        irq;
      logic        wake;
   } sct_state_t;
endpackage
`default_nettype wire

// >>> hw/sct_timer.sv
/*
   Sixteen-bit capture/compare timer with one-pulse and PWM modes, reached
   over AXI4-Lite.
   Assumes capture, external clock and CPU state inputs are synchronous to
   aclk, and that no bus access happens while the CPU is halted.
*/
// Implementation choices: the register offsets and the AXI4-Lite register port.
`default_nettype none
module sct_timer (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        cpu_wait,
   input  wire logic        cpu_halt,
   input  wire logic        cpu_irq_mask,
   input  wire logic        capture_pin_one,
   input  wire logic        capture_pin_two,
   input  wire logic        external_count_pin,
   output logic             compare_pin_one,
   output logic             compare_pin_one_oe,
   output logic             compare_pin_two,
   output logic             compare_pin_two_oe,
   output logic             timer_irq,
   output logic             timer_wake
);
   // ----------------------------------------
   // State and working signals
   // ----------------------------------------
   sct_pkg::sct_state_t q;
   sct_pkg::sct_state_t d;
   logic        run;
   logic        hexit;
   logic        pwm_on;
   logic        opm_on;
   logic        ext_edge;
   logic        tick;
   logic        e1;
   logic        e2;
   logic        ovf;
   logic        m1;
   logic        m2;
   logic        do_wr;
   logic        do_rd;
   logic        rd_sr;
   logic        irq_now;
   logic [15:0] cnt_nx;
   logic [4:0]  set_f;
   logic [4:0]  acc;
   logic [4:0]  clr;
   logic [8:0]  rd_r;
   logic [8:0]  rd_w;

   // ----------------------------------------
   // Register read multiplexer
   // ----------------------------------------
   function automatic logic [8:0] rd_mux(
      input logic [7:0]          a,
      input sct_pkg::sct_state_t s
   );
      logic [8:0] r;
      r = {1'b1, 8'h00};
      if (a == sct_pkg::A_CTL1)
         r = {1'b0, s.ctl1};
      else if (a == sct_pkg::A_CTL2)
         r = {1'b0, s.ctl2};
      else if (a == sct_pkg::A_FLAGS)
         r = {1'b0, s.flags, sct_pkg::FLAGS_PAD};
      else if (a == sct_pkg::A_CAP1_HI)
         r = {1'b0, s.cap1[15:8]};
      else if (a == sct_pkg::A_CAP1_LO)
         r = {1'b0, s.cap1[7:0]};
      else if (a == sct_pkg::A_CAP2_HI)
         r = {1'b0, s.cap2[15:8]};
      else if (a == sct_pkg::A_CAP2_LO)
         r = {1'b0, s.cap2[7:0]};
      else if (a == sct_pkg::A_CMP1_HI)
         r = {1'b0, s.cmp1[15:8]};
      else if (a == sct_pkg::A_CMP1_LO)
         r = {1'b0, s.cmp1[7:0]};
      else if (a == sct_pkg::A_CMP2_HI)
         r = {1'b0, s.cmp2[15:8]};
      else if (a == sct_pkg::A_CMP2_LO)
         r = {1'b0, s.cmp2[7:0]};
      else if (a == sct_pkg::A_CNT_HI || a == sct_pkg::A_ALT_HI)
         r = {1'b0, s.cnt[15:8]};
      else if (a == sct_pkg::A_CNT_LO || a == sct_pkg::A_ALT_LO)
         r = {1'b0, s.cnt[7:0]};
      return r;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      d = q;
      run = !cpu_halt;
      hexit = q.halt_q && !cpu_halt;
      pwm_on = q.ctl2[sct_pkg::B2_PWM];
      opm_on = q.ctl2[sct_pkg::B2_ONE_PULSE] && !pwm_on;
      if (q.ctl2[sct_pkg::B2_EXT_EDGE])
         ext_edge = external_count_pin && !q.ext_q;
      else
         ext_edge = !external_count_pin && q.ext_q;
      // A divided tick is taken from the free prescaler, so the first tick
      // after a selection change may come early by up to one period.
      case (q.ctl2[sct_pkg::B2_CLK_HI:sct_pkg::B2_CLK_LO])
         sct_pkg::CLK_DIV4: tick = run && (q.pre[1:0] == 2'h3);
         sct_pkg::CLK_DIV2: tick = run && q.pre[0];
         sct_pkg::CLK_DIV8: tick = run && (q.pre == 3'h7);
         default:           tick = run && ext_edge;
      endcase
      if (q.ctl1[sct_pkg::B1_EDGE1])
         e1 = capture_pin_one && !q.cap1_q;
      else
         e1 = !capture_pin_one && q.cap1_q;
      if (q.ctl2[sct_pkg::B2_EDGE2])
         e2 = capture_pin_two && !q.cap2_q;
      else
         e2 = !capture_pin_two && q.cap2_q;
      cnt_nx = q.cnt + 16'h0001;
      ovf = tick && (q.cnt == sct_pkg::CNT_MAX);
      // At divide by two a match shows while the counter equals the compare
      // value; with the other clock selections, external clock included, it shows one count later.
      if (q.ctl2[sct_pkg::B2_CLK_HI:sct_pkg::B2_CLK_LO] == sct_pkg::CLK_DIV2)
      begin
         m1 = tick && (cnt_nx == q.cmp1) && !q.cmp_inh[0];
         m2 = tick && (cnt_nx == q.cmp2) && !q.cmp_inh[1];
      end
      else
      begin
         m1 = tick && (q.cnt == q.cmp1) && !q.cmp_inh[0];
         m2 = tick && (q.cnt == q.cmp2) && !q.cmp_inh[1];
      end
      d.ext_q = external_count_pin;
      d.cap1_q = capture_pin_one;
      d.cap2_q = capture_pin_two;
      d.halt_q = cpu_halt;
      set_f = 5'h00;
      if (run)
         d.pre = q.pre + 3'h1;
      if (tick)
         d.cnt = cnt_nx;
      if (ovf)
         set_f[sct_pkg::F_OVF] = 1'b1;
      if (m1)
      begin
         d.pin1 = q.ctl1[sct_pkg::B1_LVL1];
         if (!pwm_on && !opm_on)
            set_f[sct_pkg::F_CMP1] = 1'b1;
      end
      if (m2 && !pwm_on)
         set_f[sct_pkg::F_CMP2] = 1'b1;
      // ----------------------------------------
      // Capture one and the waveform modes
      // ----------------------------------------
      if (pwm_on)
      begin
         if (m2)
         begin
            d.cnt = sct_pkg::CNT_RST;
            d.pin1 = q.ctl1[sct_pkg::B1_LVL2];
            set_f[sct_pkg::F_CAP1] = 1'b1;
         end
      end
      else if (opm_on)
      begin
         if (run && e1)
         begin
            d.cnt = sct_pkg::CNT_RST;
            d.cap1 = sct_pkg::CAP_OPM;
            d.pin1 = q.ctl1[sct_pkg::B1_LVL2];
            set_f[sct_pkg::F_CAP1] = 1'b1;
         end
      end
      else
      begin
         if (q.ctl1[sct_pkg::B1_FORCE1])
            d.pin1 = q.ctl1[sct_pkg::B1_LVL1];
         if (m2 || q.ctl1[sct_pkg::B1_FORCE2])
            d.pin2 = q.ctl1[sct_pkg::B1_LVL2];
         if (run && e1)
         begin
            d.cap1 = q.cnt;
            set_f[sct_pkg::F_CAP1] = 1'b1;
         end
         else if (!run && e1)
            d.halt_arm[0] = 1'b1;
         else if (hexit && q.halt_arm[0])
         begin
            d.cap1 = q.cnt;
            d.halt_arm[0] = 1'b0;
            set_f[sct_pkg::F_CAP1] = 1'b1;
         end
      end
      // ----------------------------------------
      // Capture two
      // ----------------------------------------
      if (run && e2)
      begin
         d.cap2 = q.cnt;
         set_f[sct_pkg::F_CAP2] = 1'b1;
      end
      else if (!run && e2)
         d.halt_arm[1] = 1'b1;
      else if (hexit && q.halt_arm[1])
      begin
         d.cap2 = q.cnt;
         d.halt_arm[1] = 1'b0;
         set_f[sct_pkg::F_CAP2] = 1'b1;
      end
      // ----------------------------------------
      // Bus write channel
      // ----------------------------------------
      do_wr = q.aw_got && q.w_got && !q.bvalid;
      rd_w = rd_mux(q.awaddr, q);
      if (s_axi_awvalid && q.awready)
      begin
         d.aw_got = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready)
      begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata[7:0];
         d.wstrb0 = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready)
         d.bvalid = 1'b0;
      if (do_wr)
      begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = rd_w[8] ? sct_pkg::RESP_ERR : sct_pkg::RESP_OK;
         if (q.wstrb0)
         begin
            if (q.awaddr == sct_pkg::A_CTL1)
               d.ctl1 = q.wdata;
            else if (q.awaddr == sct_pkg::A_CTL2)
               d.ctl2 = q.wdata;
            else if (q.awaddr == sct_pkg::A_CMP1_HI)
            begin
               d.cmp1[15:8] = q.wdata;
               d.cmp_inh[0] = 1'b1;
            end
            else if (q.awaddr == sct_pkg::A_CMP1_LO)
            begin
               d.cmp1[7:0] = q.wdata;
               d.cmp_inh[0] = 1'b0;
            end
            else if (q.awaddr == sct_pkg::A_CMP2_HI)
            begin
               d.cmp2[15:8] = q.wdata;
               d.cmp_inh[1] = 1'b1;
            end
            else if (q.awaddr == sct_pkg::A_CMP2_LO)
            begin
               d.cmp2[7:0] = q.wdata;
               d.cmp_inh[1] = 1'b0;
            end
            else if (q.awaddr == sct_pkg::A_CNT_LO || q.awaddr == sct_pkg::A_ALT_LO)
               d.cnt = sct_pkg::CNT_RST;
         end
      end
      // ----------------------------------------
      // Bus read channel
      // ----------------------------------------
      do_rd = s_axi_arvalid && q.arready;
      rd_r = rd_mux(s_axi_araddr, q);
      rd_sr = do_rd && (s_axi_araddr == sct_pkg::A_FLAGS);
      if (q.rvalid && s_axi_rready)
         d.rvalid = 1'b0;
      if (do_rd)
      begin
         d.rvalid = 1'b1;
         d.rdata = rd_r[7:0];
         d.rresp = rd_r[8] ? sct_pkg::RESP_ERR : sct_pkg::RESP_OK;
      end
      // ----------------------------------------
      // Two-step flag clearing
      // ----------------------------------------
      acc = 5'h00;
      acc[sct_pkg::F_CAP1] =
         (do_rd && s_axi_araddr == sct_pkg::A_CAP1_LO) ||
         (do_wr && q.wstrb0 && q.awaddr == sct_pkg::A_CAP1_LO);
      acc[sct_pkg::F_CMP1] =
         (do_rd && s_axi_araddr == sct_pkg::A_CMP1_LO) ||
         (do_wr && q.wstrb0 && q.awaddr == sct_pkg::A_CMP1_LO);
      // The alternate counter low byte is left out on purpose.
      acc[sct_pkg::F_OVF] =
         (do_rd && s_axi_araddr == sct_pkg::A_CNT_LO) ||
         (do_wr && q.wstrb0 && q.awaddr == sct_pkg::A_CNT_LO);
      acc[sct_pkg::F_CAP2] =
         (do_rd && s_axi_araddr == sct_pkg::A_CAP2_LO) ||
         (do_wr && q.wstrb0 && q.awaddr == sct_pkg::A_CAP2_LO);
      acc[sct_pkg::F_CMP2] =
         (do_rd && s_axi_araddr == sct_pkg::A_CMP2_LO) ||
         (do_wr && q.wstrb0 && q.awaddr == sct_pkg::A_CMP2_LO);
      clr = acc & q.arm;
      // A new event in the clearing cycle survives.
      d.flags = (q.flags & ~clr) | set_f;
      d.arm = (q.arm & ~clr) | (rd_sr ? q.flags : sct_pkg::FLAGS_RST);
      // ----------------------------------------
      // Interrupt and wake request
      // ----------------------------------------
      irq_now = !cpu_irq_mask && !cpu_halt && (
         (q.ctl1[sct_pkg::B1_CAP_IE] &&
            (d.flags[sct_pkg::F_CAP1] || d.flags[sct_pkg::F_CAP2])) ||
         (q.ctl1[sct_pkg::B1_CMP_IE] &&
            (d.flags[sct_pkg::F_CMP1] || d.flags[sct_pkg::F_CMP2])) ||
         (q.ctl1[sct_pkg::B1_OVF_IE] && d.flags[sct_pkg::F_OVF]));
      d.irq = irq_now;
      d.wake = irq_now && cpu_wait;
      d.awready = !d.aw_got && !d.bvalid;
      d.wready = !d.w_got && !d.bvalid;
      d.arready = !d.rvalid;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q <= '0;
         q.ctl1 <= sct_pkg::CTL_RST;
         q.ctl2 <= sct_pkg::CTL_RST;
         q.flags <= sct_pkg::FLAGS_RST;
         q.cnt <= sct_pkg::CNT_RST;
         q.cmp1 <= sct_pkg::CMP_RST;
         q.cmp2 <= sct_pkg::CMP_RST;
      end
      else
         q <= d;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bresp = q.bresp;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_arready = q.arready;
   assign s_axi_rdata = {24'h000000, q.rdata};
   assign s_axi_rresp = q.rresp;
   assign s_axi_rvalid = q.rvalid;
   assign compare_pin_one = q.pin1;
   assign compare_pin_one_oe = q.ctl2[sct_pkg::B2_PIN1_EN];
   assign compare_pin_two = q.pin2;
   assign compare_pin_two_oe = q.ctl2[sct_pkg::B2_PIN2_EN];
   assign timer_irq = q.irq;
   assign timer_wake = q.wake;
endmodule
`default_nettype wire

// >>> verif/sct_far_end.sv
/*
   Pins around the timer: capture inputs and a gated external count clock.
   Assumes the bench sets capture levels and gating right after aclk edges.
*/
`default_nettype none
module sct_far_end (
   input  wire logic       aclk,
   input  wire logic [1:0] cap_lvl,
   input  wire logic       ext_go,
   output logic            capture_pin_one,
   output logic            capture_pin_two,
   output logic            external_count_pin,
   output logic [7:0]      n_rise,
   output logic [7:0]      n_fall
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph = 2'h0;
   initial external_count_pin = 1'b0;
   initial n_rise = 8'h00;
   initial n_fall = 8'h00;
   assign capture_pin_one = cap_lvl[0];
   assign capture_pin_two = cap_lvl[1];
   // The count clock stands still while not gated, so ticks are exactly countable.
   always @(posedge aclk)
   begin
      if (ext_go)
      begin
         ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
         if (ph == 2'h2)
         begin
            external_count_pin <= !external_count_pin;
            if (external_count_pin)
               n_fall <= n_fall + 8'h01;
            else
               n_rise <= n_rise + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verif/sct_timer_props.sv
/*
   Checker of the timer's read data, pin enables and interrupt outputs.
   Assumes it is bound to sct_timer, whose ports carry the same names.
*/
`default_nettype none
module sct_timer_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        cpu_wait,
   input wire logic        cpu_halt,
   input wire logic        cpu_irq_mask,
   input wire logic        compare_pin_one_oe,
   input wire logic        compare_pin_two_oe,
   input wire logic        timer_irq,
   input wire logic        timer_wake
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   logic [7:0] ra_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // The read address is kept so that read data can be judged by register.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ra_q <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready)
         ra_q <= s_axi_araddr;
   end
   a_flags_pad_zero:
      assert property (s_axi_rvalid && ra_q == sct_pkg::A_FLAGS |-> s_axi_rdata[2:0] == 3'h0
         && s_axi_rdata[31:8] == 24'h000000) else $error("flags pad bits not zero.");
   a_cap_byte_wide:
      assert property (s_axi_rvalid && (ra_q == sct_pkg::A_CAP1_HI || ra_q == sct_pkg::A_CAP1_LO)
         |-> s_axi_rdata[31:8] == 24'h000000) else $error("capture byte too wide.");
   a_irq_masked:
      assert property (cpu_irq_mask |=> !timer_irq) else $error("irq while masked.");
   a_irq_halt_low:
      assert property (cpu_halt |=> !timer_irq) else $error("irq while halted.");
   a_wake_wait_only:
      assert property (!cpu_wait |=> !timer_wake) else $error("wake outside wait.");
   a_wake_halt_none:
      assert property (cpu_halt [*2] |=> !timer_wake) else $error("wake from halt.");
   a_oe_from_ctl:
      assert property (s_axi_rvalid && ra_q == sct_pkg::A_CTL2 |-> s_axi_rdata[7] ==
         compare_pin_one_oe && s_axi_rdata[6] == compare_pin_two_oe) else $error("oe mismatch.");
   a_irq_no_enable:
      assert property (s_axi_rvalid && ra_q == sct_pkg::A_CTL1 && s_axi_rdata[7:5] == 3'h0
         |-> !timer_irq) else $error("irq without enable.");
endmodule
bind sct_timer sct_timer_chk i_sct_timer_chk (.*);
`default_nettype wire

// >>> verif/tb_sct_timer.sv
/*
   Self-checking bench of the capture/compare timer over AXI4-Lite.
   Assumes the checker is bound by its own file and the far-end model drives the pins.
*/
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_sct_timer;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0, aresetn = 1'b0, cpu_wait = 1'b0, cpu_halt = 1'b0, cpu_irq_mask = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, n_rise, n_fall;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ext_go = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rng = 32'h0001_1244;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r, cap_lvl = 2'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        capture_pin_one, capture_pin_two, external_count_pin, timer_irq, timer_wake;
   logic        compare_pin_one, compare_pin_one_oe, compare_pin_two, compare_pin_two_oe;
   logic [7:0]  a, b, c, d;
   int          n_fail = 0, n_compared = 0, cyc = 0, t0, e;
   sct_timer i_sct_timer (.*);
   sct_far_end i_sct_far_end (.*);
   always #5 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;
   // ----------------------------------------
   // Bus tasks and expectations
   // ----------------------------------------
   function automatic int div_of(input logic [1:0] s);
      return (s == sct_pkg::CLK_DIV2) ? 2 : (s == sct_pkg::CLK_DIV8) ? 8 : 4;
   endfunction
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_awaddr  <= ad;
      s_axi_wdata   <= {24'h000000, dt};
      s_axi_wstrb   <= 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] ad, output logic [7:0] dt, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr  <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      dt = s_axi_rdata[7:0];
      rs = s_axi_rresp;
   endtask
   task automatic cap_case(input int p, input logic pol);
      int fb;
      logic [7:0] lo;
      fb = p ? 3 + sct_pkg::F_CAP2 : 3 + sct_pkg::F_CAP1;
      lo = p ? sct_pkg::A_CAP2_LO : sct_pkg::A_CAP1_LO;
      wr(p ? sct_pkg::A_CTL2 : sct_pkg::A_CTL1, {6'h00, pol, 1'b0}, r);
      cap_lvl[p] <= pol;
      repeat (4) @(posedge aclk);
      rd(sct_pkg::A_FLAGS, d, r);
      rd(lo, d, r);
      cap_lvl[p] <= !pol;
      repeat (4) @(posedge aclk);
      rd(sct_pkg::A_FLAGS, d, r);
      `CHK("capture_wrong_edge", 1'b0, d[fb])
      cap_lvl[p] <= pol;
      repeat (4) @(posedge aclk);
      rd(sct_pkg::A_FLAGS, d, r);
      `CHK("capture_flag_set", 1'b1, d[fb])
      rd(lo, d, r);
      rd(sct_pkg::A_FLAGS, d, r);
      `CHK("capture_flag_clear", 1'b0, d[fb])
      $display("test capture pin %0d edge %0d done", p, pol);
   endtask
   task wrap_up;
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   // All tests take about one thousand cycles, so a hang is cut well short of the run limit.
   initial
   begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      $display("[ERR] watchdog expected finish seen hang");
      wrap_up();
   end
   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(sct_pkg::A_FLAGS, d, r);
      `CHK("flags_reset", 8'h00, d)
      rd(sct_pkg::A_CTL1, d, r);
      `CHK("ctl1_reset", 8'h00, d)
      rd(sct_pkg::A_CTL2, d, r);
      `CHK("ctl2_reset", 8'h00, d)
      rd(8'h3c, d, r);
      `CHK("unmapped_resp", sct_pkg::RESP_ERR, r)
      wr(sct_pkg::A_CTL1, 8'h20, r);
      wr(sct_pkg::A_CNT_LO, 8'h00, r);
      rd(sct_pkg::A_CNT_HI, d, r);
      `CHK("count_restart_hi", 8'hff, d)
      repeat (40) @(posedge aclk);
      `CHK("irq_on_overflow", 1'b1, timer_irq)
      cpu_wait <= 1'b1;
      repeat (2) @(posedge aclk);
      `CHK("wake_in_wait", 1'b1, timer_wake)
      cpu_wait <= 1'b0;
      cpu_irq_mask <= 1'b1;
      repeat (2) @(posedge aclk);
      `CHK("irq_masked", 1'b0, timer_irq)
      cpu_irq_mask <= 1'b0;
      wr(sct_pkg::A_CTL1, 8'h00, r);
      repeat (2) @(posedge aclk);
      `CHK("irq_disabled", 1'b0, timer_irq)
      wr(sct_pkg::A_FLAGS, 8'h00, r);
      `CHK("flags_write_resp", sct_pkg::RESP_OK, r)
      rd(sct_pkg::A_FLAGS, d, r);
      `CHK("flags_read_only", 1'b1, d[3 + sct_pkg::F_OVF])
      rd(sct_pkg::A_ALT_LO, d, r);
      rd(sct_pkg::A_FLAGS, d, r);
      `CHK("ovf_kept_by_alt", 1'b1, d[3 + sct_pkg::F_OVF])
      rd(sct_pkg::A_CNT_LO, d, r);
      rd(sct_pkg::A_FLAGS, d, r);
      `CHK("ovf_cleared", 1'b0, d[3 + sct_pkg::F_OVF])
      $display("test overflow and interrupt done");
      wr(sct_pkg::A_CTL1, 8'h02, r);
      rd(sct_pkg::A_CNT_LO, b, r);
      cpu_halt <= 1'b1;
      repeat (20) @(posedge aclk);
      cap_lvl[0] <= 1'b1;
      repeat (180) @(posedge aclk);
      cpu_halt <= 1'b0;
      rd(sct_pkg::A_CNT_LO, a, r);
      `CHK("halt_freeze", 1'b1, 8'(a - b) < 8'h08)
      rd(sct_pkg::A_FLAGS, d, r);
      `CHK("halt_capture_flag", 1'b1, d[3 + sct_pkg::F_CAP1])
      rd(sct_pkg::A_CAP1_LO, c, r);
      `CHK("halt_capture_value", 1'b1, 8'(a - c) < 8'h02)
      cap_lvl[0] <= 1'b0;
      $display("test halt done");
      for (int s = 0; s < 3; s++)
      begin
         wr(sct_pkg::A_CTL2, {4'h0, 2'(s), 2'h0}, r);
         rd(sct_pkg::A_CNT_LO, b, r);
         t0 = cyc;
         repeat (64) @(posedge aclk);
         rd(sct_pkg::A_CNT_LO, a, r);
         e = (cyc - t0) / div_of(2'(s));
         `CHK("tick_rate", 1'b1, int'(8'(a - b)) >= e - 1 && int'(8'(a - b)) <= e + 1)
      end
      for (int x = 0; x < 2; x++)
      begin
         wr(sct_pkg::A_CTL2, {6'h03, 1'b0, 1'(x)}, r);
         rd(sct_pkg::A_CNT_LO, b, r);
         c = x ? n_rise : n_fall;
         ext_go <= 1'b1;
         repeat (60) @(posedge aclk);
         ext_go <= 1'b0;
         repeat (4) @(posedge aclk);
         rd(sct_pkg::A_CNT_LO, a, r);
         `CHK("ext_ticks", 8'((x ? n_rise : n_fall) - c), 8'(a - b))
      end
      $display("test clock select done");
      wr(sct_pkg::A_CTL2, 8'hc0, r);
      wr(sct_pkg::A_CTL1, 8'h19, r);
      repeat (2) @(posedge aclk);
      `CHK("force_lvl1", 4'he, {compare_pin_one_oe, compare_pin_one, compare_pin_two_oe, compare_pin_two})
      wr(sct_pkg::A_CTL1, 8'h1c, r);
      repeat (2) @(posedge aclk);
      `CHK("force_lvl2", 4'hb, {compare_pin_one_oe, compare_pin_one, compare_pin_two_oe, compare_pin_two})
      wr(sct_pkg::A_CTL2, 8'h00, r);
      repeat (2) @(posedge aclk);
      `CHK("pins_released", 2'h0, {compare_pin_one_oe, compare_pin_two_oe})
      $display("test forced outputs done");
      for (int i = 0; i < 4; i++)
      begin
         c = 8'(xs());
         wr(sct_pkg::A_CTL1, c, r);
         rd(sct_pkg::A_CTL1, d, r);
         `CHK("ctl1_readback", c, d)
      end
      wr(sct_pkg::A_CTL1, 8'h09, r);
      wr(sct_pkg::A_CTL1, 8'h00, r);
      wr(sct_pkg::A_CMP1_HI, 8'h00, r);
      wr(sct_pkg::A_CMP1_LO, 8'h10, r);
      wr(sct_pkg::A_CNT_LO, 8'h00, r);
      repeat (99) @(posedge aclk);
      rd(sct_pkg::A_FLAGS, d, r);
      `CHK("cmp1_flag", 1'b1, d[3 + sct_pkg::F_CMP1])
      `CHK("cmp1_pin", 1'b0, compare_pin_one)
      $display("test readback and compare done");
      for (int p = 0; p < 2; p++)
         for (int q = 0; q < 2; q++)
            cap_case(p, 1'(q));
      wrap_up();
   end
endmodule
`default_nettype wire
